// *** apop_pkg.sv ***
/*
  Package for the converter parallel output port: widths, pipeline depth,
  carrier structs.
  Assumes one system clock clk_sys (100 MHz) and an async active-low reset.
*/
package apop_pkg;
  localparam int          RES_W      = 10;
  localparam int          PIPE_DEPTH = 2;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;

  typedef struct packed {
    logic [RES_W-1:0] data;
    logic [RES_W-1:0] oe;
  } apop_bus_t;

  typedef struct packed {
    logic [2:0]       clk_sync;
    logic             clk_level;
    logic [2:0]       stby_sync;
    logic             standby;
    logic [2:0]       oen_sync;
    logic             out_en_n;
    logic [RES_W-1:0] stage0;
    logic [RES_W-1:0] stage1;
    logic [RES_W-1:0] result;
    apop_bus_t        bus;
  } apop_state_t;
endpackage : apop_pkg

// *** apop_port.sv ***
/*
  Digital side of a pipelined 10-bit converter: samples on falling converter
  clock edges, two-stage pipeline, tri-state parallel result bus.
  Assumes conv_clk, standby_request, out_en_n and analog_input come from
  outside clk_sys; analog_input is the already quantised code.
  Holds the pin filters, the sample pipeline, the bus drivers and the
  assertions that guard them.
  Assumes analog_input is steady from before a falling converter clock edge
  until that edge has passed the pin filter, about four clk_sys cycles.
  Assumes the converter clock half period is well above four clk_sys cycles,
  so no edge is lost in the filter.
  The pad ring builds the tri-state pads from result_bits and result_bits_oe.
  Assumes nothing else drives the result pads.
*/
`timescale 1ns/10ps
module apop_port
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      conv_clk,
  input  wire logic                      standby_request,
  input  wire logic                      out_en_n,
  input  wire logic [apop_pkg::RES_W-1:0] analog_input,
  output logic      [apop_pkg::RES_W-1:0] result_bits,
  output logic      [apop_pkg::RES_W-1:0] result_bits_oe,
  output logic                            standby
);
  apop_pkg::apop_state_t st;
  apop_pkg::apop_state_t next_st;
  logic                  fall_edge;
  logic                  drive;
  logic                  clk_agree;
  logic                  stby_agree;
  logic                  oen_agree;

  always_comb
  begin
    next_st = st;
    next_st.clk_sync  = {st.clk_sync[1:0], conv_clk};
    next_st.stby_sync = {st.stby_sync[1:0], standby_request};
    next_st.oen_sync  = {st.oen_sync[1:0], out_en_n};
    // Three-stage sync; level accepted once stages two and three agree
    clk_agree  = (st.clk_sync[1] == st.clk_sync[2]);
    stby_agree = (st.stby_sync[1] == st.stby_sync[2]);
    oen_agree  = (st.oen_sync[1] == st.oen_sync[2]);
    if (clk_agree)
      next_st.clk_level = st.clk_sync[2];
    if (stby_agree)
      next_st.standby = st.stby_sync[2];
    if (oen_agree)
      next_st.out_en_n = st.oen_sync[2];
    // One detection per edge: the filtered level drops in the same step
    fall_edge = st.clk_level && clk_agree && !st.clk_sync[2];
    // Standby freezes the pipeline, so stale codes appear after release
    if (fall_edge && !st.standby)
    begin
      next_st.stage0 = analog_input;
      next_st.stage1 = st.stage0;
      next_st.result = st.stage1;
    end
    drive = !st.out_en_n && !st.standby;
    next_st.bus.data = next_st.result;
    next_st.bus.oe   = drive ? '1 : '0;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st <= '{clk_sync: 3'h0, clk_level: 1'b0, stby_sync: 3'h0, standby: 1'b0,
              oen_sync: 3'h7, out_en_n: 1'b1, stage0: apop_pkg::RES_RST,
              stage1: apop_pkg::RES_RST, result: apop_pkg::RES_RST,
              bus: '{data: apop_pkg::RES_RST, oe: 10'h000}};
    end
    else
      st <= next_st;
  end

  assign result_bits    = st.bus.data;
  assign result_bits_oe = st.bus.oe;
  assign standby        = st.standby;

  // Pin filters: a change counts only once two stages agree
  // Glitches shorter than one clk_sys cycle never reach the pipeline
  a_clk_sync_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1
    |=> st.clk_sync[2:1] == $past(st.clk_sync[1:0]))
    else $error("converter clock filter did not shift");

  a_clk_level_take: assert property (@(posedge clk_sys) disable iff (!nrst)
    clk_agree
    |=> st.clk_level == $past(st.clk_sync[2]))
    else $error("agreed clock level not taken");

  a_clk_level_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !clk_agree
    |=> $stable(st.clk_level))
    else $error("clock level moved while stages disagree");

  a_fall_once: assert property (@(posedge clk_sys) disable iff (!nrst)
    fall_edge
    |=> !fall_edge)
    else $error("falling edge detected twice");

  a_stby_sync_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1
    |=> st.stby_sync[2:1] == $past(st.stby_sync[1:0]))
    else $error("standby filter did not shift");

  a_stby_take: assert property (@(posedge clk_sys) disable iff (!nrst)
    stby_agree
    |=> standby == $past(st.stby_sync[2]))
    else $error("agreed standby level not taken");

  a_stby_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !stby_agree
    |=> $stable(standby))
    else $error("standby moved while stages disagree");

  a_oen_sync_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1
    |=> st.oen_sync[2:1] == $past(st.oen_sync[1:0]))
    else $error("enable filter did not shift");

  a_oen_take: assert property (@(posedge clk_sys) disable iff (!nrst)
    oen_agree
    |=> st.out_en_n == $past(st.oen_sync[2]))
    else $error("agreed enable level not taken");

  a_oen_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !oen_agree
    |=> $stable(st.out_en_n))
    else $error("enable moved while stages disagree");

  // Sample pipeline and bus word
  a_sample_on_fall: assert property (@(posedge clk_sys) disable iff (!nrst)
    (fall_edge && !st.standby)
    |=> st.stage0 == $past(analog_input))
    else $error("sample not taken at falling edge");

  a_binary_pass: assert property (@(posedge clk_sys) disable iff (!nrst)
    (fall_edge && !st.standby)
    |=> st.stage0[apop_pkg::RES_W-1] == $past(analog_input[apop_pkg::RES_W-1]))
    else $error("top bit altered on capture");

  a_pipe_shift: assert property (@(posedge clk_sys) disable iff (!nrst)
    (fall_edge && !st.standby)
    |=> st.result == $past(st.stage1) && st.stage1 == $past(st.stage0))
    else $error("pipeline did not advance");

  a_stage_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fall_edge
    |=> $stable(st.stage0) && $stable(st.stage1))
    else $error("pipeline moved without falling edge");

  a_hold_between: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fall_edge
    |=> $stable(st.result))
    else $error("result changed without falling edge");

  a_stby_freeze: assert property (@(posedge clk_sys) disable iff (!nrst)
    st.standby
    |=> $stable(st.stage0) && $stable(st.stage1) && $stable(st.result))
    else $error("pipeline moved during standby");

  a_bus_data: assert property (@(posedge clk_sys) disable iff (!nrst)
    (fall_edge && !st.standby)
    |=> result_bits == $past(st.stage1))
    else $error("bus word differs from pipeline");

  a_bus_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !fall_edge
    |=> $stable(result_bits))
    else $error("bus word changed without falling edge");

  // Bus enables; the pads float whenever a bit of oe is low
  // Enables are filtered too, so the bus floats about five cycles late
  a_float_on_stby: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(st.standby)
    |-> result_bits_oe == 10'h000)
    else $error("bus driven during standby");

  a_float_on_oen: assert property (@(posedge clk_sys) disable iff (!nrst)
    $past(st.out_en_n)
    |-> result_bits_oe == 10'h000)
    else $error("bus driven with enable high");

  a_drive_when_en: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!st.out_en_n && !st.standby)
    |=> result_bits_oe == 10'h3FF)
    else $error("bus not driven while enabled");

  a_oe_uniform: assert property (@(posedge clk_sys) disable iff (!nrst)
    1'b1
    |-> result_bits_oe == 10'h000 || result_bits_oe == 10'h3FF)
    else $error("bus enables differ between bits");

  a_oe_rise_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(result_bits_oe[0])
    |-> !$past(st.out_en_n) && !$past(st.standby))
    else $error("bus enabled without both enables low");

  a_oe_fall_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    $fell(result_bits_oe[0])
    |-> $past(st.out_en_n) || $past(st.standby))
    else $error("bus released without a cause");

  a_stby_pin_float: assert property (@(posedge clk_sys) disable iff (!nrst)
    standby
    |=> result_bits_oe == 10'h000)
    else $error("bus driven while standby shown");

  a_oe_stable: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($stable(st.out_en_n) && $stable(st.standby))
    |=> $stable(result_bits_oe))
    else $error("bus enable moved with steady enables");

  a_drive_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    result_bits_oe == 10'h3FF
    |-> !$past(st.out_en_n) && !$past(st.standby))
    else $error("bus driven without both enables low");

endmodule : apop_port

// *** apop_cap.sv ***
/* Capture logic model: makes conv_clk, latches the bus on its rising edge.
   Assumes a resolved bus from the bench. */
`timescale 1ns/10ps
module apop_cap
(
  input  wire logic       run,
  input  wire logic [9:0] bus_in,
  output logic            conv_clk,
  output logic [9:0]      captured
);
  // Stands still high when stopped; 6.25 MHz, under the rated rate
  initial
  begin
    conv_clk = 1'b1;
    forever #80 if (run) conv_clk = ~conv_clk;
  end
  always @(posedge conv_clk) captured <= bus_in;
endmodule : apop_cap

// *** apop_port_tb_top.sv ***
/* Bench for apop_port: codes through the pipeline, then the enables.
   Assumes apop_pkg, apop_port and apop_cap compiled first. */
`timescale 1ns/10ps
module apop_port_tb_top;
  logic                       clk_sys = 1'b0, nrst = 1'b0, run = 1'b0, conv_clk, standby;
  logic                       standby_request = 1'b0, out_en_n = 1'b0;
  logic [apop_pkg::RES_W-1:0] analog_input = 10'h000, result_bits, oe, captured, bus;
  int                         mismatches = 0, checks = 0, cycles = 0;
  // Floating bits read inverted so a released bus never matches
  assign bus = (result_bits & oe) | (~result_bits & ~oe);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  apop_port DUT (.clk_sys(clk_sys), .nrst(nrst), .conv_clk(conv_clk),
    .standby_request(standby_request), .out_en_n(out_en_n), .analog_input(analog_input),
    .result_bits(result_bits), .result_bits_oe(oe), .standby(standby));
  apop_cap cap (.run(run), .bus_in(bus), .conv_clk(conv_clk), .captured(captured));
  function automatic logic [9:0] code(input int i);
    return (i % 2) ? ~(10'h001 << i) : (10'h001 << i);
  endfunction : code
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stream_codes();
    run = 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      @(posedge conv_clk) #1;
      if (i >= 3) check(captured, code(i - 3));
      @(negedge clk_sys) analog_input = code(i);
    end
    run = 1'b0;
    $display("stream_codes done");
  endtask : stream_codes
  task automatic walk_enables();
    for (int k = 0; k < 4; k++)
    begin
      @(negedge clk_sys) {standby_request, out_en_n} = k[1:0];
      repeat (8) @(negedge clk_sys);
      check(oe, (k == 0) ? 10'h3FF : 10'h000);
      check({9'h000, standby}, {9'h000, standby_request});
    end
    $display("walk_enables done");
  endtask : walk_enables
  task automatic standby_refill();
    @(negedge clk_sys) {standby_request, out_en_n} = 2'b00;
    repeat (8) @(negedge clk_sys);
    analog_input = 10'h2AA;
    run = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge conv_clk) #1;
      // First two captures after release hold stale codes and are skipped
      if (i == 2) check(captured, 10'h2AA);
      if (i >= 3) check(captured, code(i - 3));
      @(negedge clk_sys) analog_input = code(i);
    end
    run = 1'b0;
    $display("standby_refill done");
  endtask : standby_refill
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (8) @(negedge clk_sys);
    stream_codes();
    walk_enables();
    standby_refill();
    report_and_stop();
  end
endmodule : apop_port_tb_top
